// File: hdl/isw_pkg.sv
/*
 * Package for the system control block: the watchdog, the interrupt
 * controller, the stack engine and the power manager.
 * It holds the register offsets, field positions, reset values and counts,
 * and the carrier types shared by the design and the bench.
 * It assumes a single 50 MHz core clock domain.
 */
package isw_pkg;

    // ------------------------------------------------------------
    // register map (4-bit index, 8-bit data)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_MISC = 4'h0;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h1;
    localparam logic [3:0] REG_IRQ_FLAGS = 4'h2;
    localparam logic [3:0] REG_EDGE_LO = 4'h3;
    localparam logic [3:0] REG_EDGE_HI = 4'h4;
    localparam logic [3:0] REG_STACK_POINTER = 4'h5;
    localparam logic [3:0] REG_DIER_A = 4'h6;
    localparam logic [3:0] REG_DIER_B = 4'h7;
    localparam logic [3:0] REG_COMP_CTRL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MISC_WDT_SEL_LSB = 0;
    localparam int MISC_WDT_EN_BIT = 2;
    localparam int MISC_EXT_SEL_BIT = 3;
    localparam int COMP_EN_BIT = 7;
    localparam int COMP_WAKE_BIT = 6;
    localparam int PIN_A0_IDX = 0;
    localparam int PIN_A5_IDX = 5;
    localparam int PIN_B0_IDX = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    // ------------------------------------------------------------
    // counts and addresses
    // ------------------------------------------------------------
    localparam int WDT_CLK_8K = 8192;
    localparam int WDT_CLK_16K = 16384;
    localparam int WDT_CLK_64K = 65536;
    localparam int WDT_CLK_256K = 262144;
    localparam logic [17:0] WDT_LAST_8K = 18'(WDT_CLK_8K - 1);
    localparam logic [17:0] WDT_LAST_16K = 18'(WDT_CLK_16K - 1);
    localparam logic [17:0] WDT_LAST_64K = 18'(WDT_CLK_64K - 1);
    localparam logic [17:0] WDT_LAST_256K = 18'(WDT_CLK_256K - 1);
    localparam int WAKE_SLOW_TICKS = 3000;
    localparam logic [11:0] WAKE_LAST = 12'(WAKE_SLOW_TICKS - 1);
    localparam logic [15:0] IRQ_VECTOR = 16'h0010;
    localparam logic [7:0] SP_STEP = 8'h02;

    // edge selection codes per source
    localparam logic [1:0] EDGE_BOTH = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_LIGHT = 2'b01,
        PWR_DEEP = 2'b10,
        PWR_WAKE = 2'b11
    } isw_pwr_t;

    // one-cycle instruction strobes from the core
    typedef struct packed {
        logic engint;
        logic disgint;
        logic reti;
        logic pushaf;
        logic popaf;
        logic stopexe;
        logic stopsys;
        logic wdreset;
    } isw_cmd_t;

    // per-timer state from the three timers (wide, narrow a, narrow b)
    typedef struct packed {
        logic [2:0] clk_is_sys;
        logic [2:0] osc_on;
        logic [2:0] match;
    } isw_tmr_t;

endpackage : isw_pkg

// File: hdl/isw_ctrl.sv
/*
 * System control block: watchdog on the slow oscillator, eight-source
 * interrupt controller with stack entry and return, accumulator/flag
 * push and pop, and the light/deep sleep power manager.
 * Assumes the core, timers, comparator and touch unit run on core_clk_i;
 * the pins and the slow oscillator output are asynchronous.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module isw_ctrl #(
    parameter int PIN_W = 16,
    parameter int STACK_WORDS = 64
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic slow_rc_osc_i,
    input wire logic [PIN_W-1:0] pins_i,
    input wire logic [PIN_W-1:0] pin_is_input_i,
    input wire logic [5:0] periph_src_i,
    input wire logic comparator_out_i,
    input wire isw_pkg::isw_tmr_t tmr_i,
    input wire isw_pkg::isw_cmd_t cmd_i,
    input wire logic core_ready_i,
    input wire logic [15:0] core_pc_i,
    input wire logic [15:0] core_af_i,
    output logic pc_load_o,
    output logic [15:0] pc_value_o,
    output logic [15:0] af_value_o,
    output logic af_load_o,
    output logic gie_o,
    output logic wdt_rst_o,
    output logic sys_clk_en_o,
    output logic osc_en_o,
    output logic prog_mem_en_o,
    output logic [2:0] timer_run_o
);
    import isw_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0] misc;
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_flags;
    logic [15:0] edge_sel;
    logic [7:0] stack_pointer;
    logic [PIN_W-1:0] pin_digital_input_enable;
    logic [7:0] comp_ctrl;
    logic gie;
    isw_pwr_t pwr_state;
    logic [17:0] watchdog_counter;
    logic [11:0] wake_cnt;
    logic [15:0] stack_mem [STACK_WORDS];

    logic [PIN_W-1:0] pin_sync1;
    logic [PIN_W-1:0] pin_sync2;
    logic [PIN_W-1:0] pin_prev;
    logic slow_sync1;
    logic slow_sync2;
    logic slow_prev;
    logic [7:0] src_prev;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_misc = reg_wr_i && reg_addr_i == REG_MISC;
    wire wr_en = reg_wr_i && reg_addr_i == REG_IRQ_ENABLE;
    wire wr_flags = reg_wr_i && reg_addr_i == REG_IRQ_FLAGS;
    wire wr_edge_lo = reg_wr_i && reg_addr_i == REG_EDGE_LO;
    wire wr_edge_hi = reg_wr_i && reg_addr_i == REG_EDGE_HI;
    wire wr_sp = reg_wr_i && reg_addr_i == REG_STACK_POINTER;
    wire wr_dier_a = reg_wr_i && reg_addr_i == REG_DIER_A;
    wire wr_dier_b = reg_wr_i && reg_addr_i == REG_DIER_B;
    wire wr_comp = reg_wr_i && reg_addr_i == REG_COMP_CTRL;

    wire [7:0] status_val = {gie, 5'h00, pwr_state};
    wire [7:0] rd_mux =
        (reg_addr_i == REG_MISC) ? misc :
        (reg_addr_i == REG_IRQ_ENABLE) ? irq_enable_reg :
        (reg_addr_i == REG_IRQ_FLAGS) ? irq_flags :
        (reg_addr_i == REG_EDGE_LO) ? edge_sel[7:0] :
        (reg_addr_i == REG_EDGE_HI) ? edge_sel[15:8] :
        (reg_addr_i == REG_STACK_POINTER) ? stack_pointer :
        (reg_addr_i == REG_DIER_A) ? pin_digital_input_enable[7:0] :
        (reg_addr_i == REG_DIER_B) ? pin_digital_input_enable[15:8] :
        (reg_addr_i == REG_COMP_CTRL) ? comp_ctrl :
        (reg_addr_i == REG_STATUS) ? status_val : 8'h00;

    // ------------------------------------------------------------
    // slow oscillator tick and watchdog
    // ------------------------------------------------------------
    wire slow_tick = slow_sync2 && !slow_prev;
    wire [1:0] wdt_sel = misc[MISC_WDT_SEL_LSB +: 2];
    wire wdt_en = misc[MISC_WDT_EN_BIT];
    wire [17:0] wdt_last =
        (wdt_sel == 2'b00) ? WDT_LAST_8K :
        (wdt_sel == 2'b01) ? WDT_LAST_16K :
        (wdt_sel == 2'b10) ? WDT_LAST_64K : WDT_LAST_256K;
    wire wdt_expire = wdt_en && slow_tick && watchdog_counter == wdt_last;
    wire wdt_clear = !wdt_en || cmd_i.wdreset || wdt_expire;
    wire [17:0] next_wdt = wdt_clear ? 18'h00000 :
        (slow_tick ? watchdog_counter + 18'h00001 : watchdog_counter);

    // ------------------------------------------------------------
    // interrupt sources and edge detection
    // ------------------------------------------------------------
    wire ext_a = misc[MISC_EXT_SEL_BIT] ? pin_sync2[PIN_A5_IDX]
                                        : pin_sync2[PIN_A0_IDX];
    wire [7:0] src_now = {periph_src_i, pin_sync2[PIN_B0_IDX],
                          ext_a};
    logic [7:0] src_event;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_edge
            wire rise = src_now[gi] && !src_prev[gi];
            wire fall = !src_now[gi] && src_prev[gi];
            wire [1:0] es = edge_sel[2*gi +: 2];
            assign src_event[gi] = (es == EDGE_RISE) ? rise :
                (es == EDGE_FALL) ? fall : (rise || fall);
        end
    endgenerate

    // set wins over a software clear in the same cycle
    wire [7:0] next_flags = (wr_flags ? (irq_flags & reg_wdata_i) : irq_flags)
                            | src_event;
    wire irq_pending = |(irq_flags & irq_enable_reg);
    wire any_cmd = |cmd_i;
    wire take_irq = gie && irq_pending && core_ready_i && !any_cmd
                    && pwr_state == PWR_RUN;

    // ------------------------------------------------------------
    // stack engine
    // ------------------------------------------------------------
    wire [7:0] sp_up = stack_pointer + SP_STEP;
    wire [7:0] sp_dn = stack_pointer - SP_STEP;
    localparam int SI_W = $clog2(STACK_WORDS);
    wire [SI_W-1:0] push_idx = stack_pointer[SI_W:1];
    wire [SI_W-1:0] pop_idx = sp_dn[SI_W:1];
    wire do_push = take_irq || cmd_i.pushaf;
    wire [15:0] push_data = take_irq ? core_pc_i : core_af_i;
    wire do_pop = cmd_i.reti || cmd_i.popaf;

    wire [7:0] next_sp = wr_sp ? reg_wdata_i :
        do_push ? sp_up : (do_pop ? sp_dn : stack_pointer);

    wire next_gie = take_irq ? 1'b0 :
        (cmd_i.reti || cmd_i.engint) ? 1'b1 :
        (cmd_i.disgint ? 1'b0 : gie);

    // ------------------------------------------------------------
    // wake detection
    // ------------------------------------------------------------
    wire pin_wake = |((pin_sync2 ^ pin_prev) & pin_digital_input_enable
                      & pin_is_input_i);
    wire tmr_wake = |(tmr_i.match & ~tmr_i.clk_is_sys);
    wire cmp_wake = comp_ctrl[COMP_EN_BIT] && comp_ctrl[COMP_WAKE_BIT]
                    && comparator_out_i;
    wire light_wake = pin_wake || tmr_wake || cmp_wake;
    wire deep_wake = pin_wake;

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    isw_pwr_t next_pwr;
    always_comb begin
        next_pwr = pwr_state;
        unique case (pwr_state)
            PWR_RUN: begin
                if (cmd_i.stopsys) begin
                    next_pwr = PWR_DEEP;
                end else if (cmd_i.stopexe) begin
                    next_pwr = PWR_LIGHT;
                end
            end
            PWR_LIGHT: begin
                if (light_wake) begin
                    next_pwr = PWR_WAKE;
                end
            end
            PWR_DEEP: begin
                if (deep_wake) begin
                    next_pwr = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                if (slow_tick && wake_cnt == WAKE_LAST) begin
                    next_pwr = PWR_RUN;
                end
            end
        endcase
    end

    wire [11:0] next_wake_cnt = (pwr_state != PWR_WAKE) ? 12'h000 :
        (slow_tick ? wake_cnt + 12'h001 : wake_cnt);

    // clock gates follow the next state so they flip with it
    wire next_sys_clk_en = next_pwr == PWR_RUN;
    wire next_osc_en = next_pwr != PWR_DEEP;
    wire [2:0] light_timers = tmr_i.osc_on & ~tmr_i.clk_is_sys;
    wire [2:0] next_timer_run = (next_pwr == PWR_RUN) ? 3'h7 :
        (next_pwr == PWR_DEEP) ? 3'h0 : light_timers;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
            slow_sync1 <= 1'b0;
            slow_sync2 <= 1'b0;
        end else if (ce_i) begin
            pin_sync1 <= pins_i;
            pin_sync2 <= pin_sync1;
            slow_sync1 <= slow_rc_osc_i;
            slow_sync2 <= slow_sync1;
        end
    end

    // ------------------------------------------------------------
    // history and watchdog
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_prev <= '0;
            slow_prev <= 1'b0;
            src_prev <= 8'h00;
            watchdog_counter <= 18'h00000;
            wdt_rst_o <= 1'b0;
        end else if (ce_i) begin
            pin_prev <= pin_sync2;
            slow_prev <= slow_sync2;
            src_prev <= src_now;
            watchdog_counter <= next_wdt;
            wdt_rst_o <= wdt_expire;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            misc <= MISC_RST;
            irq_enable_reg <= REG8_RST;
            edge_sel <= {REG8_RST, REG8_RST};
            pin_digital_input_enable <= '0;
            comp_ctrl <= REG8_RST;
            irq_flags <= REG8_RST;
        end else if (ce_i) begin
            if (wr_misc) misc <= reg_wdata_i;
            if (wr_en) irq_enable_reg <= reg_wdata_i;
            if (wr_edge_lo) edge_sel[7:0] <= reg_wdata_i;
            if (wr_edge_hi) edge_sel[15:8] <= reg_wdata_i;
            if (wr_dier_a) pin_digital_input_enable[7:0] <= reg_wdata_i;
            if (wr_dier_b) pin_digital_input_enable[15:8] <= reg_wdata_i;
            if (wr_comp) comp_ctrl <= reg_wdata_i;
            irq_flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // stack memory, no reset needed on contents
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (ce_i && do_push) begin
            stack_mem[push_idx] <= push_data;
        end
    end

    // ------------------------------------------------------------
    // core hand-off and power outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stack_pointer <= REG8_RST;
            gie <= 1'b0;
            pc_load_o <= 1'b0;
            pc_value_o <= PC_RST;
            af_load_o <= 1'b0;
            af_value_o <= PC_RST;
            reg_rdata_o <= 8'h00;
            pwr_state <= PWR_RUN;
            wake_cnt <= 12'h000;
        end else if (ce_i) begin
            stack_pointer <= next_sp;
            gie <= next_gie;
            pc_load_o <= take_irq || cmd_i.reti;
            if (take_irq) begin
                pc_value_o <= IRQ_VECTOR;
            end else if (cmd_i.reti) begin
                pc_value_o <= stack_mem[pop_idx];
            end
            af_load_o <= cmd_i.popaf;
            if (cmd_i.popaf) begin
                af_value_o <= stack_mem[pop_idx];
            end
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
            pwr_state <= next_pwr;
            wake_cnt <= next_wake_cnt;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gie_o <= 1'b0;
            sys_clk_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            prog_mem_en_o <= 1'b1;
            timer_run_o <= 3'h7;
        end else if (ce_i) begin
            gie_o <= next_gie;
            sys_clk_en_o <= next_sys_clk_en;
            osc_en_o <= next_osc_en;
            prog_mem_en_o <= next_sys_clk_en;
            timer_run_o <= next_timer_run;
        end
    end

endmodule : isw_ctrl

// File: sim/isw_core_model.sv
/*
 * Core model: program counter that runs while the system clock is on
 * and loads on pc_load; ready on every other count.
 * Assumes the control block on the same core clock.
 */
`timescale 1ns/10ps
module isw_core_model (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic pc_load_i,
    input wire logic [15:0] pc_value_i,
    input wire logic sys_clk_en_i,
    output logic core_ready_o,
    output logic [15:0] core_pc_o,
    output logic [15:0] core_af_o
);
    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_pc_o <= 16'h0100;
        end else if (pc_load_i) begin
            core_pc_o <= pc_value_i;
        end else if (sys_clk_en_i) begin
            core_pc_o <= core_pc_o + 16'h0001;
        end
    end
    // slow answer: boundary only on even counts
    assign core_ready_o = ~core_pc_o[0];
    assign core_af_o = {core_pc_o[7:0], ~core_pc_o[15:8]};
endmodule : isw_core_model

// File: sim/isw_ctrl_sva.sv
/*
 * Port checker for the system control block.
 * Assumes one core clock domain; attached by the bind below.
 */
`timescale 1ns/10ps
module isw_ctrl_sva
    import isw_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire isw_pkg::isw_tmr_t tmr_i,
    input wire isw_pkg::isw_cmd_t cmd_i,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_value_o,
    input wire logic af_load_o,
    input wire logic gie_o,
    input wire logic sys_clk_en_o,
    input wire logic osc_en_o,
    input wire logic prog_mem_en_o,
    input wire logic [2:0] timer_run_o
);
    import isw_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_entry;
        $fell(gie_o) && !$past(cmd_i.disgint);
    endsequence
    sequence s_slept;
        !sys_clk_en_o && osc_en_o && $past(ce_i);
    endsequence
    a_entry_vector: assert property (s_entry |-> pc_load_o
        && pc_value_o == IRQ_VECTOR) else $error("bad entry");
    a_reti_return: assert property (cmd_i.reti && ce_i |=>
        pc_load_o && gie_o) else $error("bad return");
    a_global_on: assert property (cmd_i.engint && ce_i |=> gie_o)
        else $error("global enable not set");
    a_global_off: assert property (cmd_i.disgint && ce_i
        |=> !gie_o) else $error("global enable not cleared");
    a_pop_load: assert property (cmd_i.popaf && ce_i
        |=> af_load_o) else $error("no restore pulse");
    a_light_entry: assert property (cmd_i.stopexe && sys_clk_en_o
        && ce_i |=> !sys_clk_en_o && osc_en_o) else $error("bad light");
    a_deep_entry: assert property (cmd_i.stopsys && sys_clk_en_o
        && ce_i |=> !sys_clk_en_o && !osc_en_o) else $error("bad deep");
    a_mem_follow: assert property (prog_mem_en_o == sys_clk_en_o)
        else $error("memory enable differs");
    a_light_timers: assert property (s_slept ##1 s_slept |->
        timer_run_o == $past(tmr_i.osc_on & ~tmr_i.clk_is_sys))
        else $error("timer run wrong");
endmodule : isw_ctrl_sva

bind isw_ctrl isw_ctrl_sva isw_ctrl_sva_i (.core_clk_i, .resetn_i, .ce_i,
    .tmr_i, .cmd_i, .pc_load_o, .pc_value_o, .af_load_o, .gie_o,
    .sys_clk_en_o, .osc_en_o, .prog_mem_en_o, .timer_run_o);

// File: sim/isw_ctrl_test.sv
/*
 * Self-checking bench for the system control block.
 * Assumes the core model beside it and the bound port checker.
 */
`timescale 1ns/10ps
module isw_ctrl_test;
    import isw_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic slow_rc_osc_i = 1'b0;
    logic [15:0] pins_i = 16'h0000;
    logic [15:0] pin_is_input_i = 16'h0100;
    logic [5:0] periph_src_i = 6'h00;
    logic comparator_out_i = 1'b0;
    isw_tmr_t tmr_i = '0;
    isw_cmd_t cmd_i = '0;
    logic core_ready_i, pc_load_o, af_load_o, gie_o, wdt_rst_o;
    logic sys_clk_en_o, osc_en_o, prog_mem_en_o;
    logic [7:0] reg_rdata_o, v;
    logic [15:0] core_pc_i, core_af_i, pc_value_o, af_value_o, pcs, afs;
    logic [2:0] timer_run_o;
    logic [1:0] slow_ph = 2'b00;
    int error_cnt = 0;
    int check_count = 0;
    int cyc_cnt = 0;
    int n;
    isw_ctrl isw_ctrl_i (.core_clk_i, .resetn_i, .ce_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .slow_rc_osc_i,
        .pins_i, .pin_is_input_i, .periph_src_i, .comparator_out_i, .tmr_i,
        .cmd_i, .core_ready_i, .core_pc_i, .core_af_i, .pc_load_o,
        .pc_value_o, .af_value_o, .af_load_o, .gie_o, .wdt_rst_o,
        .sys_clk_en_o, .osc_en_o, .prog_mem_en_o, .timer_run_o);
    isw_core_model isw_core_model_i (.core_clk_i, .resetn_i,
        .pc_load_i(pc_load_o), .pc_value_i(pc_value_o),
        .sys_clk_en_i(sys_clk_en_o), .core_ready_o(core_ready_i),
        .core_pc_o(core_pc_i), .core_af_o(core_af_i));
    // ------------------------------------------------------------
    // clocks, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    // slow clock: one tick per 4 core cycles, still while oscillators off
    always @(posedge core_clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (osc_en_o === 1'b1) begin
            slow_ph <= slow_ph + 2'b01;
            slow_rc_osc_i <= slow_ph[1];
        end
        if (cyc_cnt == 90000) begin
            error_cnt++;
            test_done;
        end
    end
    task automatic test_done;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask : rd_chk
    task automatic do_cmd(input isw_cmd_t c);
        @(posedge core_clk_i);
        cmd_i <= c;
        @(negedge core_clk_i);
        if (c.pushaf) afs = core_af_i;
        @(posedge core_clk_i);
        cmd_i <= '0;
    endtask : do_cmd
    task automatic wait_run(input int lo, input int hi);
        n = 0;
        while (sys_clk_en_o !== 1'b1 && n < hi) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(16'(n > lo && n < hi), 16'h0001);
    endtask : wait_run
    function automatic logic hit(input logic [1:0] c, input logic rise);
        return (c == EDGE_RISE) ? rise : (c == EDGE_FALL) ? !rise : 1'b1;
    endfunction : hit
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hded2));
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(negedge core_clk_i);
        chk(16'({gie_o, osc_en_o, sys_clk_en_o, timer_run_o}), 16'h001F);
        for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00);
        do_cmd(isw_cmd_t'(8'h01));
        for (int a = 1; a < 16; a++) begin
            v = 8'($urandom) & 8'hFE;
            wr_reg(4'(a), v);
            if (a != 2) rd_chk(4'(a), (a < 9) ? v : 8'h00);
        end
        wr_reg(REG_IRQ_ENABLE, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr_reg(REG_EDGE_LO, {4{2'(c)}});
            wr_reg(REG_EDGE_HI, {4{2'(c)}});
            wr_reg(REG_IRQ_FLAGS, 8'h00);
            @(posedge core_clk_i) periph_src_i <= 6'h3F;
            rd_chk(REG_IRQ_FLAGS, {{6{hit(2'(c), 1'b1)}}, 2'b00});
            wr_reg(REG_IRQ_FLAGS, 8'h00);
            @(posedge core_clk_i) periph_src_i <= 6'h00;
            rd_chk(REG_IRQ_FLAGS, {{6{hit(2'(c), 1'b0)}}, 2'b00});
        end
        wr_reg(REG_IRQ_FLAGS, 8'h0C);
        rd_chk(REG_IRQ_FLAGS, 8'h0C);
        wr_reg(REG_IRQ_FLAGS, 8'h00);
        wr_reg(REG_MISC, 8'h00);
        @(posedge core_clk_i) pins_i <= 16'h0001;
        repeat (4) @(posedge core_clk_i);
        rd_chk(REG_IRQ_FLAGS, 8'h01);
        wr_reg(REG_IRQ_FLAGS, 8'h00);
        wr_reg(REG_MISC, 8'h08);
        @(posedge core_clk_i) pins_i <= 16'h0121;
        repeat (4) @(posedge core_clk_i);
        rd_chk(REG_IRQ_FLAGS, 8'h03);
        // pending flags are not enabled: no entry may happen
        wr_reg(REG_STACK_POINTER, 8'h10);
        wr_reg(REG_IRQ_ENABLE, 8'h04);
        do_cmd(isw_cmd_t'(8'h80));
        repeat (4) @(posedge core_clk_i);
        chk(16'(gie_o), 16'h0001);
        ce_i <= 1'b0;
        do_cmd(isw_cmd_t'(8'h40));
        ce_i <= 1'b1;
        chk(16'(gie_o), 16'h0001);
        pcs = core_pc_i;
        @(posedge core_clk_i) periph_src_i <= 6'h01;
        n = 0;
        @(negedge core_clk_i);
        while (pc_load_o !== 1'b1 && n < 20) begin
            pcs = core_pc_i;
            @(negedge core_clk_i);
            n++;
        end
        chk(pc_value_o, IRQ_VECTOR);
        chk(16'(gie_o), 16'h0000);
        rd_chk(REG_STACK_POINTER, 8'h12);
        do_cmd(isw_cmd_t'(8'h10));
        rd_chk(REG_STACK_POINTER, 8'h14);
        wr_reg(REG_IRQ_FLAGS, 8'h00);
        do_cmd(isw_cmd_t'(8'h08));
        @(negedge core_clk_i);
        chk(af_value_o, afs);
        do_cmd(isw_cmd_t'(8'h20));
        @(negedge core_clk_i);
        chk(pc_value_o, pcs);
        chk(16'(gie_o), 16'h0001);
        rd_chk(REG_STACK_POINTER, 8'h10);
        do_cmd(isw_cmd_t'(8'h40));
        do_cmd(isw_cmd_t'(8'h80));
        // watchdog is off in misc before sleeping
        @(posedge core_clk_i) tmr_i <= {3'b010, 3'b111, 3'b000};
        do_cmd(isw_cmd_t'(8'h04));
        @(negedge core_clk_i);
        chk(16'({osc_en_o, sys_clk_en_o, timer_run_o}), 16'h0015);
        @(posedge core_clk_i) tmr_i.match <= 3'b010;
        repeat (3) @(posedge core_clk_i);
        rd_chk(REG_STATUS, 8'h81);
        @(posedge core_clk_i) tmr_i.match <= 3'b001;
        wait_run(11950, 12060);
        @(posedge core_clk_i) tmr_i.match <= 3'b000;
        wr_reg(REG_COMP_CTRL, 8'h80);
        do_cmd(isw_cmd_t'(8'h04));
        @(posedge core_clk_i) comparator_out_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rd_chk(REG_STATUS, 8'h81);
        @(posedge core_clk_i) comparator_out_i <= 1'b0;
        wr_reg(REG_COMP_CTRL, 8'hC0);
        @(posedge core_clk_i) comparator_out_i <= 1'b1;
        wait_run(11950, 12060);
        wr_reg(REG_DIER_B, 8'h01);
        @(posedge core_clk_i) comparator_out_i <= 1'b0;
        do_cmd(isw_cmd_t'(8'h02));
        @(negedge core_clk_i);
        chk(16'({osc_en_o, sys_clk_en_o, prog_mem_en_o}), 16'h0);
        @(posedge core_clk_i) tmr_i.match <= 3'b001;
        @(posedge core_clk_i) comparator_out_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        rd_chk(REG_STATUS, 8'h82);
        @(posedge core_clk_i) pins_i <= 16'h0021;
        wait_run(11950, 12080);
        rd_chk(REG_STACK_POINTER, 8'h10);
        do_cmd(isw_cmd_t'(8'h01));
        wr_reg(REG_MISC, 8'h04);
        n = 0;
        while (wdt_rst_o !== 1'b1 && n < 33000) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(16'(n > 32700 && n < 32850), 16'h0001);
        // after the expiry pulse the bench pulses the chip reset itself
        @(posedge core_clk_i) resetn_i <= 1'b0;
        @(posedge core_clk_i) resetn_i <= 1'b1;
        rd_chk(REG_STACK_POINTER, 8'h00);
        test_done;
    end
endmodule : isw_ctrl_test
